// *** core/enc_filt_pkg.sv ***
package enc_filt_pkg;

    // Geometry
    localparam int NCH   = 2;   // Encoder channels
    localparam int NSIG  = 6;   // Inputs per channel: a, b, c, latch, gate, status
    localparam int NIN   = NCH * NSIG;
    localparam int CNT_W = 13;  // Width of a stability counter
    localparam int ECW   = 16;  // Width of an error counter

    // Input slots within a channel
    localparam int SIG_A      = 0;
    localparam int SIG_B      = 1;
    localparam int SIG_C      = 2;
    localparam int SIG_LATCH  = 3;
    localparam int SIG_GATE   = 4;
    localparam int SIG_STATUS = 5;

    // Error counter slots within a channel
    localparam int EC_PLAUS = 0;
    localparam int EC_LATCH = 1;
    localparam int EC_GATE  = 2;
    localparam int EC_ENC   = 3;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_MODE0  = 8'h04;
    localparam logic [7:0] REG_MODE1  = 8'h08;
    localparam logic [7:0] REG_FILT0  = 8'h0c;
    localparam logic [7:0] REG_FILT1  = 8'h10;
    localparam logic [7:0] REG_CMD    = 8'h14;
    localparam logic [7:0] REG_OP     = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1c;
    localparam logic [7:0] REG_CNT    = 8'h20;  // 0x20..0x3c, 4 per channel

    // Control field positions (channel n at n*8)
    localparam int CTRL_FDIS  = 0;
    localparam int CTRL_PLAUS = 1;
    localparam int CTRL_STEP  = 8;

    // Counter modes
    localparam logic [2:0] MODE_ENC_DIFF = 3'h0;
    localparam logic [2:0] MODE_MAX      = 3'h5;

    // Filter codes, cutoff in kHz
    localparam logic [15:0] FILT_10K  = 16'h000a;
    localparam logic [15:0] FILT_25K  = 16'h0019;
    localparam logic [15:0] FILT_50K  = 16'h0032;
    localparam logic [15:0] FILT_100K = 16'h0064;
    localparam logic [15:0] FILT_250K = 16'h00fa;
    localparam logic [15:0] FILT_500K = 16'h01f4;
    localparam logic [15:0] FILT_1M   = 16'h03e8;
    localparam logic [15:0] FILT_2M5  = 16'h09c4;
    localparam logic [15:0] FILT_5M   = 16'h1388;

    // Command codes and diagnostic text id
    localparam logic [15:0] CMD_CLR_BASE = 16'h9151;
    localparam logic [15:0] CMD_CH_STEP  = 16'h0010;
    localparam logic [15:0] DIAG_PLAUS   = 16'h8312;

    // Timing: a pulse must last half a cutoff period to pass
    localparam int CLK_PERIOD_NS = 8;
    localparam int HALF_NS_1KHZ  = 500000;

    function automatic int cyc_of(input int khz);
        return (HALF_NS_1KHZ + CLK_PERIOD_NS * khz - 1) / (CLK_PERIOD_NS * khz);
    endfunction

    localparam int CYC_10K_DEF = cyc_of(int'(FILT_10K));
    localparam logic [CNT_W-1:0] CYC_25K  = CNT_W'(cyc_of(int'(FILT_25K)));
    localparam logic [CNT_W-1:0] CYC_50K  = CNT_W'(cyc_of(int'(FILT_50K)));
    localparam logic [CNT_W-1:0] CYC_100K = CNT_W'(cyc_of(int'(FILT_100K)));
    localparam logic [CNT_W-1:0] CYC_250K = CNT_W'(cyc_of(int'(FILT_250K)));
    localparam logic [CNT_W-1:0] CYC_500K = CNT_W'(cyc_of(int'(FILT_500K)));
    localparam logic [CNT_W-1:0] CYC_1M   = CNT_W'(cyc_of(int'(FILT_1M)));
    localparam logic [CNT_W-1:0] CYC_2M5  = CNT_W'(cyc_of(int'(FILT_2M5)));
    localparam logic [CNT_W-1:0] CYC_5M   = CNT_W'(cyc_of(int'(FILT_5M)));
    localparam logic [CNT_W-1:0] CYC_STATUS = CYC_100K;

endpackage

// *** core/enc_filter_plaus.sv ***
// Notes on behaviour
// - Filter bypassed after reset, except on status.
// - Filter acts only while disable bit clear, status excepted.
// - Cutoff chosen by decimal kHz code.
// - Counter mode field encodes input type.
// - Mode write loads matching default cutoff.
// - Status input always filtered at 100 kHz.
// - Cutoff below 1 MHz also filters latch, gate.
// - Encoder track overrun increments encoder counter.
// - Separate latch and gate overrun counters.
// - Pre-op to op clears all counters.
// - Clear codes zero single filter counters.
// - A/B checked as quadrature pair.
// - Illegal transition yields no position step.
// - Plausibility check only while enabled.
// - Violation emits diagnostic event with text id.
// - Violation increments plausibility counter.
// - Violation marks cyclic data invalid.
// - Plausibility counter clears on op or code.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module enc_filter_plaus
    import enc_filt_pkg::*;
#(
    parameter int FILT_10K_CYC = CYC_10K_DEF  // Long count, shorten in sim
) (
    // Clock and reset
    input  wire logic            ref_clk_i,
    input  wire logic            sys_rst_i,
    // Encoder pins, one bit per channel
    input  wire logic [NCH-1:0]  enc_a_i,
    input  wire logic [NCH-1:0]  enc_b_i,
    input  wire logic [NCH-1:0]  enc_c_i,
    input  wire logic [NCH-1:0]  latch_i,
    input  wire logic [NCH-1:0]  gate_i,
    input  wire logic [NCH-1:0]  status_i,
    // APB slave
    input  wire logic            psel_i,
    input  wire logic            penable_i,
    input  wire logic            pwrite_i,
    input  wire logic [7:0]      paddr_i,
    input  wire logic [31:0]     pwdata_i,
    output logic      [31:0]     prdata_o,
    output logic                 pready_o,
    output logic                 pslverr_o,
    // Conditioned signals to the evaluation logic
    output logic      [NCH-1:0]  a_o,
    output logic      [NCH-1:0]  b_o,
    output logic      [NCH-1:0]  c_o,
    output logic      [NCH-1:0]  latch_o,
    output logic      [NCH-1:0]  gate_o,
    output logic      [NCH-1:0]  status_o,
    output logic      [NCH-1:0]  step_up_o,
    output logic      [NCH-1:0]  step_dn_o,
    // Diagnostics
    output logic      [NCH-1:0]  data_invalid_o,
    output logic      [NCH-1:0]  diag_event_o,
    output logic      [15:0]     diag_text_o
);

    // Whole module state
    typedef struct packed {
        logic [NIN-1:0]                  sync1;    // First sync stage
        logic [NIN-1:0]                  sync2;    // Second sync stage
        logic [NIN-1:0]                  filt;     // Accepted levels
        logic [NIN-1:0][CNT_W-1:0]       fcnt;     // Stability counters
        logic [NCH-1:0]                  filt_dis; // Filter disable
        logic [NCH-1:0]                  plaus_en; // Plausibility enable
        logic [NCH-1:0][2:0]             mode;     // Counter mode
        logic [NCH-1:0][15:0]            fcode;    // Filter code
        logic [15:0]                     cmd;      // Last command
        logic                            op;       // Operational state
        logic [NCH-1:0]                  invalid;  // Cyclic data invalid
        logic [NCH-1:0][3:0][ECW-1:0]    ecnt;     // Error counters
        logic [NCH-1:0]                  up;       // Step up pulse
        logic [NCH-1:0]                  dn;       // Step down pulse
        logic [NCH-1:0]                  diag;     // Diagnostic pulse
        logic [15:0]                     text;     // Diagnostic text id
        logic [31:0]                     prdata;   // Read data
        logic                            pready;   // Access answer
        logic                            pslverr;  // Unmapped access
    } state_t;

    state_t st;       // Current state
    state_t next_st;  // Next state

    // Cycles a level must hold for a given code
    function automatic logic [CNT_W-1:0] need_of(input logic [15:0] code);
        case (code)
            FILT_10K:  need_of = CNT_W'(FILT_10K_CYC);
            FILT_25K:  need_of = CYC_25K;
            FILT_50K:  need_of = CYC_50K;
            FILT_100K: need_of = CYC_100K;
            FILT_250K: need_of = CYC_250K;
            FILT_500K: need_of = CYC_500K;
            FILT_1M:   need_of = CYC_1M;
            FILT_2M5:  need_of = CYC_2M5;
            default:   need_of = CYC_5M;
        endcase
    endfunction

    // Only listed codes are legal
    function automatic logic code_ok(input logic [15:0] code);
        code_ok = (code == FILT_10K) || (code == FILT_25K) ||
                  (code == FILT_50K) || (code == FILT_100K) ||
                  (code == FILT_250K) || (code == FILT_500K) ||
                  (code == FILT_1M) || (code == FILT_2M5) ||
                  (code == FILT_5M);
    endfunction

    // Default cutoff per mode pair
    function automatic logic [15:0] dflt_of(input logic [2:0] m);
        case (m[2:1])
            2'h0:    dflt_of = FILT_5M;
            2'h1:    dflt_of = FILT_1M;
            default: dflt_of = FILT_100K;
        endcase
    endfunction

    // Pin bundle and channel-level events
    logic [NIN-1:0]          raw;    // Pins in slot order
    logic [NIN-1:0]          viol;   // Rejected pulse per input
    logic [NCH-1:0]          perr;   // Plausibility error
    logic [NCH-1:0][3:0]     inc;    // Counter increment requests
    logic [NCH-1:0][3:0]     clr;    // Counter clear requests

    // Per-channel pin packing and output unpacking
    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
        assign raw[ch*NSIG+SIG_A]      = enc_a_i[ch];
        assign raw[ch*NSIG+SIG_B]      = enc_b_i[ch];
        assign raw[ch*NSIG+SIG_C]      = enc_c_i[ch];
        assign raw[ch*NSIG+SIG_LATCH]  = latch_i[ch];
        assign raw[ch*NSIG+SIG_GATE]   = gate_i[ch];
        assign raw[ch*NSIG+SIG_STATUS] = status_i[ch];
        assign a_o[ch]      = st.filt[ch*NSIG+SIG_A];
        assign b_o[ch]      = st.filt[ch*NSIG+SIG_B];
        assign c_o[ch]      = st.filt[ch*NSIG+SIG_C];
        assign latch_o[ch]  = st.filt[ch*NSIG+SIG_LATCH];
        assign gate_o[ch]   = st.filt[ch*NSIG+SIG_GATE];
        assign status_o[ch] = st.filt[ch*NSIG+SIG_STATUS];
    end

    // Straight-from-flop outputs
    assign step_up_o      = st.up;
    assign step_dn_o      = st.dn;
    assign data_invalid_o = st.invalid;
    assign diag_event_o   = st.diag;
    assign diag_text_o    = st.text;
    assign prdata_o       = st.prdata;
    assign pready_o       = st.pready;
    assign pslverr_o      = st.pslverr;

    // All next-state logic
    always_comb begin
        logic              act;    // Filter applies to this input
        logic [CNT_W-1:0]  need;   // Required stable cycles
        logic              wr;     // Write takes effect now
        logic              setup;  // Setup cycle of a transfer
        logic              a_chg;
        logic              b_chg;
        int                ch;
        int                k;
        act   = 1'b0;
        need  = CYC_5M;
        ch    = 0;
        k     = 0;
        a_chg = 1'b0;
        b_chg = 1'b0;
        viol  = '0;
        perr  = '0;
        inc   = '0;
        clr   = '0;
        next_st = st;
        wr    = psel_i && penable_i && pwrite_i && st.pready;
        setup = psel_i && !penable_i;

        // Two-flop synchroniser on every pin
        next_st.sync1 = raw;
        next_st.sync2 = st.sync1;

        // Glitch filter per input
        for (int i = 0; i < NIN; i++) begin
            ch = i / NSIG;
            k  = i % NSIG;
            if (k == SIG_STATUS) begin
                act  = 1'b1;
                need = CYC_STATUS;
            end else if (k == SIG_LATCH || k == SIG_GATE) begin
                act  = !st.filt_dis[ch] && (st.fcode[ch] < FILT_1M);
                need = need_of(st.fcode[ch]);
            end else begin
                act  = !st.filt_dis[ch];
                need = need_of(st.fcode[ch]);
            end
            if (!act) begin
                // Bypass passes the synchronised level through
                next_st.filt[i] = st.sync2[i];
                next_st.fcnt[i] = '0;
            end else if (st.sync2[i] == st.filt[i]) begin
                // Level fell back early: a pulse was rejected
                viol[i]         = (st.fcnt[i] != '0);
                next_st.fcnt[i] = '0;
            end else if (CNT_W'(st.fcnt[i] + 1'b1) >= need) begin
                next_st.filt[i] = st.sync2[i];
                next_st.fcnt[i] = '0;
            end else begin
                next_st.fcnt[i] = CNT_W'(st.fcnt[i] + 1'b1);
            end
        end

        // Quadrature check and step decode
        next_st.text = DIAG_PLAUS;
        for (int c = 0; c < NCH; c++) begin
            a_chg = next_st.filt[c*NSIG+SIG_A] != st.filt[c*NSIG+SIG_A];
            b_chg = next_st.filt[c*NSIG+SIG_B] != st.filt[c*NSIG+SIG_B];
            // Both tracks moving at once is not a quadrature step
            perr[c] = a_chg && b_chg && st.plaus_en[c];
            next_st.diag[c] = perr[c];
            // Only single-track changes step, so a bad edge pair is dropped
            next_st.up[c] = (a_chg ^ b_chg) &&
                (next_st.filt[c*NSIG+SIG_A] ^ st.filt[c*NSIG+SIG_B]);
            next_st.dn[c] = (a_chg ^ b_chg) &&
                !(next_st.filt[c*NSIG+SIG_A] ^ st.filt[c*NSIG+SIG_B]);
            inc[c][EC_PLAUS] = perr[c];
            inc[c][EC_LATCH] = viol[c*NSIG+SIG_LATCH];
            inc[c][EC_GATE]  = viol[c*NSIG+SIG_GATE];
            inc[c][EC_ENC]   = viol[c*NSIG+SIG_A] ||
                viol[c*NSIG+SIG_B] || viol[c*NSIG+SIG_C];
        end

        // APB answer: ready in the first access cycle
        next_st.pready  = setup;
        next_st.pslverr = 1'b0;
        next_st.prdata  = '0;
        if (setup) begin
            if (paddr_i[1:0] != 2'h0) begin
                next_st.pslverr = 1'b1;
            end else if (paddr_i == REG_CTRL) begin
                for (int c = 0; c < NCH; c++) begin
                    next_st.prdata[c*CTRL_STEP+CTRL_FDIS]  = st.filt_dis[c];
                    next_st.prdata[c*CTRL_STEP+CTRL_PLAUS] = st.plaus_en[c];
                end
            end else if (paddr_i == REG_MODE0) begin
                next_st.prdata[2:0] = st.mode[0];
            end else if (paddr_i == REG_MODE1) begin
                next_st.prdata[2:0] = st.mode[1];
            end else if (paddr_i == REG_FILT0) begin
                next_st.prdata[15:0] = st.fcode[0];
            end else if (paddr_i == REG_FILT1) begin
                next_st.prdata[15:0] = st.fcode[1];
            end else if (paddr_i == REG_CMD) begin
                next_st.prdata[15:0] = st.cmd;
            end else if (paddr_i == REG_OP) begin
                next_st.prdata[0] = st.op;
            end else if (paddr_i == REG_STATUS) begin
                next_st.prdata[NCH-1:0] = st.invalid;
            end else if (paddr_i[7:5] == REG_CNT[7:5]) begin
                next_st.prdata[ECW-1:0] = st.ecnt[paddr_i[4]][paddr_i[3:2]];
            end else begin
                next_st.pslverr = 1'b1;
            end
        end

        // APB writes; unmapped writes change nothing
        if (wr) begin
            if (paddr_i == REG_CTRL) begin
                for (int c = 0; c < NCH; c++) begin
                    next_st.filt_dis[c] = pwdata_i[c*CTRL_STEP+CTRL_FDIS];
                    next_st.plaus_en[c] = pwdata_i[c*CTRL_STEP+CTRL_PLAUS];
                end
            end else if (paddr_i == REG_MODE0 || paddr_i == REG_MODE1) begin
                // Out-of-range modes are ignored
                if (pwdata_i[2:0] <= MODE_MAX) begin
                    next_st.mode[paddr_i[3]]  = pwdata_i[2:0];
                    next_st.fcode[paddr_i[3]] = dflt_of(pwdata_i[2:0]);
                end
            end else if (paddr_i == REG_FILT0 || paddr_i == REG_FILT1) begin
                // Filter at reg index 3 and 4: bit 2 selects channel 0
                if (code_ok(pwdata_i[15:0])) begin
                    next_st.fcode[!paddr_i[2]] = pwdata_i[15:0];
                end
            end else if (paddr_i == REG_CMD) begin
                next_st.cmd = pwdata_i[15:0];
                for (int c = 0; c < NCH; c++) begin
                    for (int j = 0; j < 4; j++) begin
                        clr[c][j] = pwdata_i[15:0] ==
                            16'(CMD_CLR_BASE + c * CMD_CH_STEP + j);
                    end
                end
            end else if (paddr_i == REG_OP) begin
                next_st.op = pwdata_i[0];
                if (pwdata_i[0] && !st.op) begin
                    clr = '1;
                end
            end else if (paddr_i == REG_STATUS) begin
                next_st.invalid = st.invalid & ~pwdata_i[NCH-1:0];
            end
        end

        // Counters and flags: an event in the clear cycle still counts
        for (int c = 0; c < NCH; c++) begin
            if (perr[c]) begin
                next_st.invalid[c] = 1'b1;
            end
            for (int j = 0; j < 4; j++) begin
                if (clr[c][j]) begin
                    next_st.ecnt[c][j] = '0;
                end
                if (inc[c][j] && next_st.ecnt[c][j] != '1) begin
                    next_st.ecnt[c][j] = ECW'(next_st.ecnt[c][j] + 1'b1);
                end
            end
        end
    end

    // State register; reset leaves all but the status filter bypassed
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st          <= '0;
            st.filt_dis <= '1;
            st.mode     <= {NCH{MODE_ENC_DIFF}};
            st.fcode    <= {NCH{FILT_5M}};
            st.text     <= DIAG_PLAUS;
        end else begin
            st <= next_st;
        end
    end

    // Checks on channel 0; the reset and op clear checks also cover channel 1, the code clear check only channel 1
    sequence s_perr0;
        st.plaus_en[0] && (next_st.filt[SIG_A] != st.filt[SIG_A]) &&
            (next_st.filt[SIG_B] != st.filt[SIG_B]);
    endsequence

    sequence s_flagged0;
        st.invalid[0] && st.diag[0] && !st.up[0] && !st.dn[0];
    endsequence

    chk_reset_bypass: assert property (@(posedge ref_clk_i)
        $fell(sys_rst_i) |-> st.filt_dis == '1 && st.fcode[0] == FILT_5M)
        else $error("filter not bypassed after reset");

    chk_bypass_follow: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        st.filt_dis[0] |=> st.filt[SIG_A] == $past(st.sync2[SIG_A]))
        else $error("bypassed track does not follow pin");

    chk_mode_default: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        psel_i && penable_i && pwrite_i && st.pready &&
        paddr_i == REG_MODE0 && pwdata_i[2:1] == 2'h1 |=>
        st.fcode[0] == FILT_1M)
        else $error("single-ended mode did not load 1 MHz");

    chk_status_hold: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        $changed(st.filt[SIG_STATUS]) |->
        $past(st.fcnt[SIG_STATUS]) == CYC_STATUS - 1'b1)
        else $error("status input passed before stable time");

    chk_latch_bypass: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        st.fcode[0] >= FILT_1M |=>
        st.filt[SIG_LATCH] == $past(st.sync2[SIG_LATCH]))
        else $error("latch filtered at 1 MHz or above");

    chk_enc_count: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        viol[SIG_A] && !clr[0][EC_ENC] && st.ecnt[0][EC_ENC] != '1 |=>
        st.ecnt[0][EC_ENC] == $past(st.ecnt[0][EC_ENC]) + 1'b1)
        else $error("encoder overrun not counted");

    chk_op_clear: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        psel_i && penable_i && pwrite_i && st.pready && paddr_i == REG_OP &&
        pwdata_i[0] && !st.op |=> st.ecnt[0][EC_LATCH] <= 1 &&
        st.ecnt[1][EC_GATE] <= 1)
        else $error("op transition did not clear counters");

    chk_cmd_clear: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        clr[1][EC_ENC] && !inc[1][EC_ENC] |=> st.ecnt[1][EC_ENC] == '0)
        else $error("clear code did not zero counter");

    chk_plaus_flag: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        s_perr0 |=> s_flagged0 ##1 !st.diag[0])
        else $error("plausibility error not flagged");

    chk_plaus_off: assert property (@(posedge ref_clk_i)
        disable iff (sys_rst_i)
        !st.plaus_en[0] |=> !st.diag[0])
        else $error("check ran while disabled");

endmodule
`default_nettype wire

// *** tb/enc_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Encoder model: drives every pin at all times, so no line floats
module enc_model
    import enc_filt_pkg::*;
(
    // Clock
    input  wire logic          clk_i,
    // Pins, slot sig*NCH+ch
    output logic     [NIN-1:0] pins_o
);
    initial pins_o = '0;
    // Gray step with A leading, so A and B stay 90 degrees apart
    task automatic quad(input int ch);
        @(posedge clk_i);
        if (pins_o[ch] == pins_o[NCH+ch]) begin
            pins_o[ch] <= ~pins_o[ch];
        end else begin
            pins_o[NCH+ch] <= ~pins_o[NCH+ch];
        end
    endtask
    // Illegal move, only on the bench's command
    task automatic both(input int ch);
        @(posedge clk_i);
        pins_o[ch] <= ~pins_o[ch];
        pins_o[NCH+ch] <= ~pins_o[NCH+ch];
    endtask
    // Pulse of len cycles on one input
    task automatic glitch(input int ch, input int sig, input int len);
        @(posedge clk_i);
        pins_o[sig*NCH+ch] <= ~pins_o[sig*NCH+ch];
        repeat (len) @(posedge clk_i);
        pins_o[sig*NCH+ch] <= ~pins_o[sig*NCH+ch];
    endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import enc_filt_pkg::*;
    logic           ref_clk_i = 1'b0;
    logic           sys_rst_i = 1'b1;
    logic           psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]     paddr = 8'h00;
    logic [31:0]    pwdata = 32'h0, prdata, rd;
    logic           pready, pslverr, err;
    logic [NCH-1:0] a, b, c, lt, gt, st, su, sd, inv, ev;
    logic [15:0]    txt;
    wire  [NIN-1:0] pins;
    int bad_count = 0, num_checks = 0, ups = 0, evs = 0, dns = 0, j, n, len;
    int seed = 32'h3f618835;
    int exp_cnt[8] = '{default: 0};  // Expected counters, ch0 slots
    int sig_of[4] = '{0, SIG_LATCH, SIG_GATE, SIG_A};
    always #4 ref_clk_i = ~ref_clk_i;
    // Tally of step and event pulses on channel 0
    always @(posedge ref_clk_i) begin
        ups <= ups + su[0];
        dns <= dns + sd[0];
        evs <= evs + ev[0];
    end
    enc_model enc_model_i (.clk_i(ref_clk_i), .pins_o(pins));
    enc_filter_plaus #(.FILT_10K_CYC(50)) enc_filter_plaus_i (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .enc_a_i(pins[1:0]), .enc_b_i(pins[3:2]), .enc_c_i(pins[5:4]),
        .latch_i(pins[7:6]), .gate_i(pins[9:8]), .status_i(pins[11:10]),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .a_o(a), .b_o(b),
        .c_o(c), .latch_o(lt), .gate_o(gt), .status_o(st),
        .step_up_o(su), .step_dn_o(sd), .data_invalid_o(inv),
        .diag_event_o(ev), .diag_text_o(txt));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    // APB transfer; request held until pready is seen
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [31:0] d);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        n = 0;
        // pready is read at the edge itself, before the slave updates it
        @(posedge ref_clk_i);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge ref_clk_i);
        end
        if (n == 16) bad_count++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0);
        check(rd, exp);
    endtask
    // Let k edges pass, then sample where outputs are settled
    task automatic idle(input int k);
        repeat (k) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog: the sequence needs under a thousand cycles
    initial begin
        #400000;
        bad_count++;
        conclude();
    end
    initial begin
        repeat (8) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        check(txt, DIAG_PLAUS);
        rdc(REG_CTRL, 32'h101);
        enc_model_i.quad(0);
        enc_model_i.quad(1);
        enc_model_i.glitch(0, SIG_STATUS, 20);
        idle(4);
        check(a[0], 1'b1);
        check(a[1], 1'b1);
        check(st[0], 1'b0);
        check(ups, 1);
        // Each mode loads its default cutoff; mode 6 is ignored
        for (j = 0; j < 7; j++) begin
            apb(1'b1, REG_MODE0, j);
            rdc(REG_FILT0, j < 2 ? FILT_5M : j < 4 ? FILT_1M : FILT_100K);
        end
        rdc(REG_MODE0, 32'h5);
        apb(1'b1, REG_CTRL, 32'h100);
        // A code off the list leaves the cutoff as it was
        apb(1'b1, REG_FILT0, 32'h7);
        rdc(REG_FILT0, FILT_100K);
        apb(1'b1, REG_FILT0, FILT_500K);
        // Short random pulses on latch, gate and A are counted once
        for (j = 1; j < 4; j++) begin
            len = 1 + ($unsigned($random(seed)) % 64);
            enc_model_i.glitch(0, sig_of[j], len);
            idle(4);
            check({c[0], gt[0], lt[0], a[0]}, 4'h1);
            exp_cnt[j]++;
            rdc(8'(REG_CNT + 4 * j), exp_cnt[j]);
        end
        // Track C overruns land in the encoder counter as well
        enc_model_i.glitch(0, SIG_C, 1 + ($unsigned($random(seed)) % 64));
        idle(4);
        check(c[0], 1'b0);
        exp_cnt[EC_ENC]++;
        rdc(8'(REG_CNT + 4 * EC_ENC), exp_cnt[EC_ENC]);
        enc_model_i.quad(0);
        idle(140);
        check(b[0], 1'b1);
        check(ups, 2);
        // A channel 1 code must leave channel 0 alone
        for (j = 1; j < 4; j++) begin
            apb(1'b1, REG_CMD, CMD_CLR_BASE + CMD_CH_STEP + j);
            rdc(8'(REG_CNT + 4 * j), exp_cnt[j]);
            apb(1'b1, REG_CMD, CMD_CLR_BASE + j);
            exp_cnt[j] = 0;
            rdc(8'(REG_CNT + 4 * j), 0);
        end
        apb(1'b1, REG_CTRL, 32'h101);
        enc_model_i.both(0);
        idle(5);
        check(evs, 0);
        check(inv[0], 1'b0);
        apb(1'b1, REG_CTRL, 32'h103);
        for (j = 1; j < 3; j++) begin
            enc_model_i.both(0);
            idle(5);
            check(evs, j);
            check(ups, 2);
            check(dns, 0);
            check(inv[0], 1'b1);
            exp_cnt[EC_PLAUS]++;
            rdc(REG_CNT, exp_cnt[EC_PLAUS]);
        end
        rdc(REG_STATUS, 32'h1);
        apb(1'b1, REG_CMD, CMD_CLR_BASE);
        rdc(REG_CNT, 0);
        enc_model_i.both(0);
        idle(5);
        rdc(REG_CNT, 1);
        apb(1'b1, REG_OP, 32'h1);
        for (j = 0; j < 8; j++) begin
            rdc(8'(REG_CNT + 4 * j), 0);
        end
        apb(1'b0, 8'h40, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
